// ---- enhanced_instruction_decode.sv ----
// enhanced instruction decoder and sequencer
`timescale 1ns/1ps
`include "decode_regs.svh"
module enhanced_instruction_decode #(
	parameter int PC_WIDTH  = 15,
	parameter int PTR_WIDTH = 16
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rstn,
	input  wire logic [13:0]          i_instr,
	input  wire logic                 i_instr_valid,
	input  wire logic [PC_WIDTH-1:0]  i_pc,
	input  wire logic [PC_WIDTH-1:0]  i_return_pc,
	input  wire logic [7:0]           i_accumulator,
	input  wire logic [7:0]           i_mem_rdata,
	input  wire logic                 i_wake,
	input  wire logic                 i_timeout_event,
	output logic                      o_busy,
	output logic                      o_pc_load,
	output logic      [PC_WIDTH-1:0]  o_pc_target,
	output logic                      o_push,
	output logic                      o_pop,
	output logic                      o_iret,
	output logic                      o_fetch_next,
	output logic      [PC_WIDTH-1:0]  o_fetch_addr,
	output logic                      o_acc_we,
	output logic      [7:0]           o_acc_wdata,
	output logic                      o_null_we,
	output logic                      o_null_flag,
	output logic                      o_mem_re,
	output logic                      o_mem_we,
	output logic      [PTR_WIDTH-1:0] o_mem_addr,
	output logic      [7:0]           o_mem_wdata,
	output logic      [7:0]           o_prescaler_config,
	output logic      [7:0]           o_direction_0,
	output logic      [7:0]           o_direction_1,
	output logic      [7:0]           o_direction_2,
	output logic                      o_wdt_clear,
	output logic                      o_soft_reset,
	output logic                      o_sleeping,
	output logic                      o_watchdog_expiry_flag,
	output logic                      o_powerdown_flag,
	output logic      [PTR_WIDTH-1:0] o_ptr0,
	output logic      [PTR_WIDTH-1:0] o_ptr1
);
	initial if (PC_WIDTH < 12 || PTR_WIDTH < 8) $error("widths too small");

	typedef enum logic [1:0] {ST_EXEC, ST_FLUSH, ST_STALL, ST_SLEEP} seq_t;

	logic [1:0] rst_sync;
	logic       rst_n;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	decode_pkg::opclass_t opc;
	logic [13:0] w;
	always_comb begin
		w = i_instr;
		if (w == `OP_NOP) opc = decode_pkg::OPC_NOP;
		else if (w == `OP_SWRESET) opc = decode_pkg::OPC_SWRESET;
		else if (w == `OP_RETURN) opc = decode_pkg::OPC_RETURN;
		else if (w == `OP_IRET) opc = decode_pkg::OPC_IRET;
		else if (w == `OP_SUBROUTINE_CALL_BY_ACCUMULATOR) opc = decode_pkg::OPC_SUBROUTINE_CALL_BY_ACCUMULATOR;
		else if (w == `OP_BRW) opc = decode_pkg::OPC_BRW;
		else if (w == `OP_PRESCALER) opc = decode_pkg::OPC_PRESCALER;
		else if (w == `OP_SLEEP) opc = decode_pkg::OPC_SLEEP;
		else if (w == `OP_WDCLR) opc = decode_pkg::OPC_WDCLR;
		// codes 0..7 of this group include prescaler/sleep/wdclr, caught above
		else if ((w & `MASK_DIR) == `PAT_DIR) opc = decode_pkg::OPC_DIR;
		else if ((w & `MASK_PTRMOV) == `PAT_PTRLD) opc = decode_pkg::OPC_PTRLD;
		else if ((w & `MASK_PTRMOV) == `PAT_PTRST) opc = decode_pkg::OPC_PTRST;
		else if ((w & `MASK_K11) == `PAT_CALL) opc = decode_pkg::OPC_CALL;
		else if ((w & `MASK_K11) == `PAT_JUMP) opc = decode_pkg::OPC_JUMP;
		else if ((w & `MASK_K9) == `PAT_BRA) opc = decode_pkg::OPC_BRA;
		else if ((w & `MASK_K8) == `PAT_RETURN_WITH_LITERAL) opc = decode_pkg::OPC_RETURN_WITH_LITERAL;
		else if ((w & `MASK_K6) == `PAT_PTRADD) opc = decode_pkg::OPC_PTRADD;
		else if ((w & `MASK_K6) == `PAT_IDXLD) opc = decode_pkg::OPC_IDXLD;
		else if ((w & `MASK_K6) == `PAT_IDXST) opc = decode_pkg::OPC_IDXST;
		else opc = decode_pkg::OPC_OTHER;
	end

	seq_t state;
	seq_t next_state;
	logic exec;
	logic mov_sel;
	logic idx_sel;
	logic sel;
	decode_pkg::ptr_mod_t mm;
	logic is_mov;
	logic is_idx;
	logic [PTR_WIDTH-1:0] addr0;
	logic [PTR_WIDTH-1:0] addr1;
	logic [PTR_WIDTH-1:0] base;
	logic [PTR_WIDTH-1:0] eff_addr;
	logic step0;
	logic step1;
	logic add0;
	logic add1;

	assign exec    = (state == ST_EXEC) && i_instr_valid;
	assign mov_sel = w[`BIT_PTRSEL_MOV];
	assign idx_sel = w[`BIT_PTRSEL];
	assign mm      = decode_pkg::ptr_mod_t'(w[1:0]);
	assign is_mov  = (opc == decode_pkg::OPC_PTRLD) || (opc == decode_pkg::OPC_PTRST);
	assign is_idx  = (opc == decode_pkg::OPC_IDXLD) || (opc == decode_pkg::OPC_IDXST);
	assign sel     = is_mov ? mov_sel : idx_sel;
	assign step0   = exec && is_mov && !mov_sel;
	assign step1   = exec && is_mov && mov_sel;
	assign add0    = exec && (opc == decode_pkg::OPC_PTRADD) && !idx_sel;
	assign add1    = exec && (opc == decode_pkg::OPC_PTRADD) && idx_sel;

	pointer_step #(.WIDTH(PTR_WIDTH)) u_ptr0 (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_add   (add0),
		.i_add_k (w[5:0]),
		.i_step  (step0),
		.i_dec   (mm[0]),
		.i_pre   (!mm[1]),
		.o_ptr   (o_ptr0),
		.o_addr  (addr0)
	);
	pointer_step #(.WIDTH(PTR_WIDTH)) u_ptr1 (
		.i_clk   (i_clk),
		.i_rst_n (rst_n),
		.i_add   (add1),
		.i_add_k (w[5:0]),
		.i_step  (step1),
		.i_dec   (mm[0]),
		.i_pre   (!mm[1]),
		.o_ptr   (o_ptr1),
		.o_addr  (addr1)
	);

	always_comb begin
		base     = sel ? addr1 : addr0;
		eff_addr = is_idx ? base + PTR_WIDTH'(w[5:0]) : base;
	end

	// registered outputs and state
	logic                 next_pc_load;
	logic [PC_WIDTH-1:0]  next_pc_target;
	logic                 next_push;
	logic                 next_pop;
	logic                 next_iret;
	logic                 next_acc_we;
	logic [7:0]           next_acc_wdata;
	logic                 next_mem_re;
	logic                 next_mem_we;
	logic [PTR_WIDTH-1:0] next_mem_addr;
	logic [7:0]           next_mem_wdata;
	logic [7:0]           next_prescaler;
	logic [7:0]           next_dir [3];
	logic [7:0]           dir [3];
	logic                 next_wdt_clear;
	logic                 next_soft_reset;
	logic                 next_expiry;
	logic                 next_powerdown;
	logic                 load_pending;
	logic                 next_load_pending;
	logic                 next_fetch_next;
	logic [PC_WIDTH-1:0]  next_fetch_addr;
	logic [PTR_WIDTH-1:0] next_rel;

	always_comb begin
		next_state       = state;
		next_pc_load     = 1'b0;
		next_pc_target   = o_pc_target;
		next_push        = 1'b0;
		next_pop         = 1'b0;
		next_iret        = 1'b0;
		next_acc_we      = 1'b0;
		next_acc_wdata   = o_acc_wdata;
		next_mem_re      = 1'b0;
		next_mem_we      = 1'b0;
		next_mem_addr    = o_mem_addr;
		next_mem_wdata   = o_mem_wdata;
		next_prescaler   = o_prescaler_config;
		next_dir         = dir;
		next_wdt_clear   = 1'b0;
		next_soft_reset  = 1'b0;
		next_expiry      = o_watchdog_expiry_flag | i_timeout_event;
		next_powerdown   = o_powerdown_flag;
		next_load_pending = 1'b0;
		next_fetch_next  = 1'b0;
		next_fetch_addr  = o_fetch_addr;
		next_rel         = '0;
		unique case (state)
			ST_EXEC: begin
				if (exec) begin
					unique case (opc)
						decode_pkg::OPC_BRA: begin
							next_pc_target = i_pc + PC_WIDTH'(1)
								+ PC_WIDTH'({{(PC_WIDTH-9){w[8]}}, w[8:0]});
							next_pc_load = 1'b1;
						end
						decode_pkg::OPC_BRW: begin
							next_pc_target = i_pc + PC_WIDTH'(1) + PC_WIDTH'(i_accumulator);
							next_pc_load = 1'b1;
						end
						decode_pkg::OPC_CALL, decode_pkg::OPC_JUMP: begin
							next_pc_target = {i_pc[PC_WIDTH-1:11], w[10:0]};
							next_pc_load = 1'b1;
							next_push = !w[11];
						end
						decode_pkg::OPC_SUBROUTINE_CALL_BY_ACCUMULATOR: begin
							next_pc_target = {i_pc[PC_WIDTH-1:8], i_accumulator};
							next_pc_load = 1'b1;
							next_push = 1'b1;
						end
						decode_pkg::OPC_RETURN, decode_pkg::OPC_IRET,
						decode_pkg::OPC_RETURN_WITH_LITERAL: begin
							next_pc_target = i_return_pc;
							next_pc_load = 1'b1;
							next_pop = 1'b1;
							next_iret = (opc == decode_pkg::OPC_IRET);
							if (opc == decode_pkg::OPC_RETURN_WITH_LITERAL) begin
								next_acc_we = 1'b1;
								next_acc_wdata = w[7:0];
							end
						end
						decode_pkg::OPC_SWRESET: next_soft_reset = 1'b1;
						decode_pkg::OPC_PRESCALER: next_prescaler = i_accumulator;
						decode_pkg::OPC_DIR: begin
							if (w[2:0] >= `DIR_SEL_FIRST)
								next_dir[2'(w[2:0] - `DIR_SEL_FIRST)] = i_accumulator;
						end
						decode_pkg::OPC_WDCLR: begin
							next_wdt_clear = 1'b1;
							next_expiry = 1'b1;
							next_powerdown = 1'b1;
						end
						decode_pkg::OPC_SLEEP: begin
							next_wdt_clear = 1'b1;
							next_expiry = 1'b1;
							next_powerdown = 1'b0;
							next_fetch_next = 1'b1;
							next_fetch_addr = i_pc + PC_WIDTH'(1);
							next_state = ST_SLEEP;
						end
						decode_pkg::OPC_PTRLD, decode_pkg::OPC_IDXLD,
						decode_pkg::OPC_PTRST, decode_pkg::OPC_IDXST: begin
							next_mem_addr = eff_addr;
							next_mem_wdata = i_accumulator;
							next_mem_re = (opc == decode_pkg::OPC_PTRLD)
								|| (opc == decode_pkg::OPC_IDXLD);
							next_mem_we = !next_mem_re;
							next_load_pending = next_mem_re;
							if (eff_addr[PTR_WIDTH-1])
								next_state = ST_STALL;
						end
						default: ;
					endcase
					if (next_pc_load)
						next_state = ST_FLUSH;
				end
			end
			ST_FLUSH: next_state = ST_EXEC;
			ST_STALL: next_state = ST_EXEC;
			ST_SLEEP: begin
				// state held in ST_SLEEP until a wake event
				if (i_wake) begin
					next_state = ST_EXEC;
					next_wdt_clear = 1'b1;
				end
			end
		endcase
	end

	logic null_flag;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state                  <= ST_EXEC;
			o_pc_load              <= 1'b0;
			o_pc_target            <= '0;
			o_push                 <= 1'b0;
			o_pop                  <= 1'b0;
			o_iret                 <= 1'b0;
			o_acc_we               <= 1'b0;
			o_acc_wdata            <= 8'h00;
			o_mem_re               <= 1'b0;
			o_mem_we               <= 1'b0;
			o_mem_addr             <= '0;
			o_mem_wdata            <= 8'h00;
			o_prescaler_config     <= `RST_PRESCALER;
			dir                    <= '{`RST_DIRECTION, `RST_DIRECTION, `RST_DIRECTION};
			o_wdt_clear            <= 1'b0;
			o_soft_reset           <= 1'b0;
			o_watchdog_expiry_flag <= `RST_EXPIRY_FLAG;
			o_powerdown_flag       <= `RST_POWERDOWN_FLAG;
			load_pending           <= 1'b0;
			o_fetch_next           <= 1'b0;
			o_fetch_addr           <= '0;
			null_flag              <= 1'b0;
		end else begin
			state                  <= next_state;
			o_pc_load              <= next_pc_load;
			o_pc_target            <= next_pc_target;
			o_push                 <= next_push;
			o_pop                  <= next_pop;
			o_iret                 <= next_iret;
			o_acc_we               <= next_acc_we | load_pending;
			o_acc_wdata            <= load_pending ? i_mem_rdata : next_acc_wdata;
			o_mem_re               <= next_mem_re;
			o_mem_we               <= next_mem_we;
			o_mem_addr             <= next_mem_addr;
			o_mem_wdata            <= next_mem_wdata;
			o_prescaler_config     <= next_prescaler;
			dir                    <= next_dir;
			o_wdt_clear            <= next_wdt_clear;
			o_soft_reset           <= next_soft_reset;
			o_watchdog_expiry_flag <= next_expiry;
			o_powerdown_flag       <= next_powerdown;
			load_pending           <= next_load_pending;
			o_fetch_next           <= next_fetch_next;
			o_fetch_addr           <= next_fetch_addr;
			if (load_pending)
				null_flag <= (i_mem_rdata == 8'h00);
		end
	end

	logic null_we;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			null_we <= 1'b0;
		else
			null_we <= load_pending;
	end

	assign o_null_we     = null_we;
	assign o_null_flag   = null_flag;
	assign o_direction_0 = dir[0];
	assign o_direction_1 = dir[1];
	assign o_direction_2 = dir[2];
	assign o_busy        = (state != ST_EXEC);
	assign o_sleeping    = (state == ST_SLEEP);
endmodule

// ---- decode_regs.svh ----
// constants for the enhanced instruction decoder
`ifndef DECODE_REGS_SVH
`define DECODE_REGS_SVH
`define OP_NOP          14'h0000
`define OP_SWRESET      14'h0001
`define OP_RETURN       14'h0008
`define OP_IRET         14'h0009
`define OP_SUBROUTINE_CALL_BY_ACCUMULATOR        14'h000a
`define OP_BRW          14'h000b
`define OP_PRESCALER    14'h0062
`define OP_SLEEP        14'h0063
`define OP_WDCLR        14'h0064
`define MASK_DIR        14'h3ff8
`define PAT_DIR         14'h0060
`define MASK_PTRMOV     14'h3ff8
`define PAT_PTRLD       14'h0010
`define PAT_PTRST       14'h0018
`define MASK_K11        14'h3800
`define PAT_CALL        14'h2000
`define PAT_JUMP        14'h2800
`define MASK_K9         14'h3e00
`define PAT_BRA         14'h3200
`define MASK_K8         14'h3f00
`define PAT_RETURN_WITH_LITERAL       14'h3400
`define MASK_K6         14'h3f80
`define PAT_PTRADD      14'h3100
`define PAT_IDXLD       14'h3f00
`define PAT_IDXST       14'h3f80
`define BIT_PTRSEL      6
`define BIT_PTRSEL_MOV  2
`define BIT_PTR_MSB     15
`define DIR_SEL_FIRST   3'h5
`define RST_EXPIRY_FLAG 1'h1
`define RST_POWERDOWN_FLAG 1'h1
`define RST_PRESCALER   8'hff
`define RST_DIRECTION   8'hff
`endif

// ---- decode_pkg.sv ----
// types for the enhanced instruction decoder
package decode_pkg;
	typedef enum logic [1:0] {
		MOD_PRE_INC,
		MOD_PRE_DEC,
		MOD_POST_INC,
		MOD_POST_DEC
	} ptr_mod_t;
	typedef enum logic [4:0] {
		OPC_NOP, OPC_SWRESET, OPC_RETURN, OPC_IRET, OPC_SUBROUTINE_CALL_BY_ACCUMULATOR, OPC_BRW,
		OPC_PRESCALER, OPC_SLEEP, OPC_WDCLR, OPC_DIR, OPC_PTRLD, OPC_PTRST,
		OPC_CALL, OPC_JUMP, OPC_BRA, OPC_RETURN_WITH_LITERAL, OPC_PTRADD, OPC_IDXLD,
		OPC_IDXST, OPC_OTHER
	} opclass_t;
endpackage

// ---- pointer_step.sv ----
// one indirect pointer with add and pre/post step
`timescale 1ns/1ps
`include "decode_regs.svh"
module pointer_step #(
	parameter int WIDTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_add,
	input  wire logic [5:0]       i_add_k,
	input  wire logic             i_step,
	input  wire logic             i_dec,
	input  wire logic             i_pre,
	output logic      [WIDTH-1:0] o_ptr,
	output logic      [WIDTH-1:0] o_addr
);
	initial if (WIDTH < 8) $error("pointer width too small");
	logic [WIDTH-1:0] ptr;
	logic [WIDTH-1:0] next_ptr;
	logic [WIDTH-1:0] stepped;
	always_comb begin
		stepped  = i_dec ? ptr - WIDTH'(1) : ptr + WIDTH'(1);
		next_ptr = ptr;
		if (i_add)
			next_ptr = ptr + WIDTH'(i_add_k);
		else if (i_step)
			next_ptr = stepped;
		// pre modifiers address the stepped value
		o_addr = (i_step && i_pre) ? stepped : ptr;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			ptr <= '0;
		else
			ptr <= next_ptr;
	end
	assign o_ptr = ptr;
endmodule

// ---- enhanced_instruction_decode_assertions.sv ----
// concurrent checks on the instruction decoder ports
`timescale 1ns/1ps
`include "decode_regs.svh"
module enhanced_instruction_decode_checker #(
	parameter int PC_WIDTH  = 15,
	parameter int PTR_WIDTH = 16
) (
	input wire logic                 i_clk,
	input wire logic                 i_rstn,
	input wire logic [13:0]          i_instr,
	input wire logic                 i_instr_valid,
	input wire logic [PC_WIDTH-1:0]  i_pc,
	input wire logic [7:0]           i_accumulator,
	input wire logic                 i_wake,
	input wire logic                 o_busy,
	input wire logic                 o_pc_load,
	input wire logic [PC_WIDTH-1:0]  o_pc_target,
	input wire logic                 o_push,
	input wire logic                 o_pop,
	input wire logic                 o_acc_we,
	input wire logic [7:0]           o_acc_wdata,
	input wire logic                 o_null_we,
	input wire logic                 o_null_flag,
	input wire logic                 o_mem_re,
	input wire logic                 o_mem_we,
	input wire logic [7:0]           o_mem_wdata,
	input wire logic [7:0]           o_prescaler_config,
	input wire logic                 o_sleeping,
	input wire logic [PC_WIDTH-1:0]  o_fetch_addr,
	input wire logic                 o_watchdog_expiry_flag,
	input wire logic                 o_powerdown_flag,
	input wire logic [PTR_WIDTH-1:0] o_ptr0,
	input wire logic [PTR_WIDTH-1:0] o_ptr1
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	logic take;
	logic low_ptrs;
	assign take = i_instr_valid && !o_busy;
	// stall cycles only add a busy cycle and leave the load pipeline timing unchanged; plain addresses here
	assign low_ptrs = !o_ptr0[PTR_WIDTH-1] && !o_ptr1[PTR_WIDTH-1];
	function automatic logic hit(input logic [13:0] w, input logic [13:0] m, input logic [13:0] p);
		return (w & m) == p;
	endfunction
	AST_BRA_TARGET: assert property (take && hit(i_instr, `MASK_K9, `PAT_BRA) |=>
		o_pc_load && o_busy && o_pc_target
		== $past(i_pc) + 1'b1 + {{(PC_WIDTH-9){$past(i_instr[8])}}, $past(i_instr[8:0])})
		else $error("relative jump target or busy cycle wrong");
	AST_CALL_PUSH: assert property (take && hit(i_instr, `MASK_K11, `PAT_CALL) |=>
		o_pc_load && o_push && o_pc_target[10:0] == $past(i_instr[10:0]))
		else $error("call did not push and load target");
	AST_RETURN_WITH_LITERAL_ACC: assert property (take && hit(i_instr, `MASK_K8, `PAT_RETURN_WITH_LITERAL) |=>
		o_pop && o_pc_load && o_acc_we && o_acc_wdata == $past(i_instr[7:0]))
		else $error("literal return wrong");
	AST_SLEEP_ENTRY: assert property (take && i_instr == `OP_SLEEP |=> o_sleeping
		&& !o_powerdown_flag && o_watchdog_expiry_flag && o_fetch_addr == $past(i_pc) + 1'b1)
		else $error("sleep entry wrong");
	AST_SLEEP_STAYS: assert property (o_sleeping && !i_wake |=> o_sleeping && o_busy)
		else $error("left sleep without wake");
	AST_PRESCALER_LOAD: assert property (take && i_instr == `OP_PRESCALER |=>
		o_prescaler_config == $past(i_accumulator))
		else $error("prescaler config not loaded");
	AST_PTRADD: assert property (take && hit(i_instr, `MASK_K6, `PAT_PTRADD) && !i_instr[6] |=>
		o_ptr0 == $past(o_ptr0) + $past(i_instr[5:0]) && !o_null_we && !o_acc_we)
		else $error("pointer add wrong");
	AST_LOAD_SEQ: assert property (take && hit(i_instr, `MASK_PTRMOV, `PAT_PTRLD) && low_ptrs
		&& i_instr[1] |=> o_mem_re ##1 (o_acc_we && o_null_we))
		else $error("pointer load sequence wrong");
	AST_NULL_VALUE: assert property (o_null_we |->
		o_acc_we && o_null_flag == (o_acc_wdata == 8'h00))
		else $error("null flag wrong");
	AST_STORE_NOFLAG: assert property (take && hit(i_instr, `MASK_PTRMOV, `PAT_PTRST) && low_ptrs
		&& i_instr[1] |=> o_mem_we && o_mem_wdata == $past(i_accumulator) && !o_null_we)
		else $error("pointer store wrong");
	COV_BRANCH: cover property (take && hit(i_instr, `MASK_K9, `PAT_BRA));
	COV_NULL_SET: cover property (o_null_we && o_null_flag);
	COV_WAKE: cover property (o_sleeping ##1 !o_sleeping);
endmodule
bind enhanced_instruction_decode enhanced_instruction_decode_checker #(
	.PC_WIDTH(PC_WIDTH), .PTR_WIDTH(PTR_WIDTH)) i_chk (.i_clk, .i_rstn, .i_instr, .i_instr_valid,
	.i_pc, .i_accumulator, .i_wake, .o_busy, .o_pc_load, .o_pc_target, .o_push, .o_pop, .o_acc_we,
	.o_acc_wdata, .o_null_we, .o_null_flag, .o_mem_re, .o_mem_we, .o_mem_wdata, .o_prescaler_config,
	.o_sleeping, .o_fetch_addr, .o_watchdog_expiry_flag, .o_powerdown_flag, .o_ptr0, .o_ptr1);

// ---- data_mem_model.sv ----
// data memory stand-in answering the decoder's reads
`timescale 1ns/1ps
module data_mem_model (
	input  wire logic        i_clk,
	input  wire logic        i_re,
	input  wire logic [15:0] i_addr,
	output logic      [7:0]  o_rdata
);
	logic [7:0] last = 8'h00;
	// outside a read the bus flips each cycle, so a late sample never matches by luck
	always_comb o_rdata = i_re ? (i_addr[7:0] ^ 8'h40) : ~last;
	always_ff @(posedge i_clk) last <= o_rdata;
endmodule

// ---- tb_enhanced_instruction_decode.sv ----
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`include "decode_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module tb_enhanced_instruction_decode;
	logic        i_clk = 1'b0, i_rstn = 1'b0, i_instr_valid = 1'b0, i_wake = 1'b0;
	logic        i_timeout_event = 1'b0;
	logic [13:0] i_instr = 14'h0000;
	logic [14:0] i_pc = 15'h0000, i_return_pc = 15'h0abc;
	logic [7:0]  i_accumulator = 8'h00, i_mem_rdata;
	logic        o_busy, o_pc_load, o_push, o_pop, o_iret, o_fetch_next, o_acc_we, o_null_we;
	logic        o_null_flag, o_mem_re, o_mem_we, o_wdt_clear, o_soft_reset, o_sleeping;
	logic        o_watchdog_expiry_flag, o_powerdown_flag;
	logic [14:0] o_pc_target, o_fetch_addr;
	logic [7:0]  o_acc_wdata, o_mem_wdata, o_prescaler_config, o_direction_0;
	logic [7:0]  o_direction_1, o_direction_2;
	logic [15:0] o_mem_addr, o_ptr0, o_ptr1;
	int          err_total = 0, comparisons = 0;
	enhanced_instruction_decode i_enhanced_instruction_decode (.*);
	data_mem_model i_data_mem_model (.i_clk, .i_re(o_mem_re), .i_addr(o_mem_addr),
		.o_rdata(i_mem_rdata));
	initial forever #20 i_clk = ~i_clk;
	// a prescaler load rides behind each word; hold=1 offers it in the busy cycle
	task automatic issue(input logic [13:0] w, input logic [14:0] p, input logic [7:0] a, input logic h);
		@(posedge i_clk);
		i_instr       <= w;
		i_pc          <= p;
		i_accumulator <= a;
		i_instr_valid <= 1'b1;
		@(posedge i_clk);
		i_instr       <= `OP_PRESCALER;
		i_instr_valid <= h;
		#1;
	endtask
	task automatic next_cycle();
		@(posedge i_clk);
		#1;
	endtask
	task automatic settle();
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	task automatic load_check(input logic [15:0] a);
		logic [7:0] d;
		d = a[7:0] ^ 8'h40;
		`CHK(o_busy, 1'b0)
		`CHK(o_mem_re, 1'b1)
		`CHK(o_mem_addr, a)
		next_cycle();
		`CHK({o_acc_we, o_acc_wdata}, {1'b1, d})
		`CHK(o_null_we, 1'b1)
		`CHK(o_null_flag, d == 8'h00)
		settle();
	endtask
	task automatic t_pointers();
		logic [15:0] ea [4] = '{16'h0011, 16'h0010, 16'h0010, 16'h0011};
		logic [15:0] ep [4] = '{16'h0011, 16'h0010, 16'h0011, 16'h0010};
		issue(`PAT_PTRLD | 14'h0001, 15'h0, 8'h0, 1'b0);
		`CHK(o_busy, 1'b1)
		settle();
		`CHK(o_ptr0, 16'hffff)
		issue(`PAT_PTRLD, 15'h0, 8'h0, 1'b0);
		settle();
		issue(`PAT_PTRADD | 14'h0010, 15'h0, 8'h0, 1'b0);
		settle();
		issue(`PAT_PTRADD | 14'h007f, 15'h0, 8'h0, 1'b0);
		settle();
		`CHK(o_ptr0, 16'h0010)
		`CHK(o_ptr1, 16'h003f)
		for (int m = 0; m < 4; m++) begin
			issue(`PAT_PTRLD | 14'(m), 15'h0, 8'h0, 1'b0);
			load_check(ea[m]);
			`CHK(o_ptr0, ep[m])
		end
		issue(`PAT_IDXLD | 14'h0041, 15'h0, 8'h0, 1'b0);
		load_check(16'h0040);
		issue(`PAT_PTRST | 14'h0006, 15'h0, 8'h77, 1'b0);
		`CHK({o_mem_we, o_mem_addr, o_mem_wdata}, {1'b1, 16'h003f, 8'h77})
		settle();
		`CHK(o_ptr1, 16'h0040)
		issue(`PAT_IDXST | 14'h0002, 15'h0, 8'h5a, 1'b0);
		`CHK({o_mem_we, o_mem_addr, o_mem_wdata}, {1'b1, 16'h0012, 8'h5a})
		settle();
		`CHK(o_null_flag, 1'b1)
	endtask
	task automatic t_branches();
		issue(`PAT_BRA | 14'h01f0, 15'h0100, 8'h11, 1'b1);
		`CHK({o_pc_load, o_busy, o_pc_target}, {2'h3, 15'h00f1})
		settle();
		`CHK(o_prescaler_config, 8'hff)
		issue(`OP_BRW, 15'h0200, 8'h20, 1'b0);
		`CHK({o_pc_load, o_pc_target}, {1'b1, 15'h0221})
		settle();
		issue(`PAT_CALL | 14'h0123, 15'h0400, 8'h0, 1'b0);
		`CHK({o_push, o_pc_load, o_pc_target[10:0]}, {2'h3, 11'h123})
		settle();
		issue(`PAT_JUMP | 14'h0456, 15'h0400, 8'h0, 1'b0);
		`CHK({o_push, o_pc_load, o_pc_target[10:0]}, {2'h1, 11'h456})
		settle();
		issue(`OP_SUBROUTINE_CALL_BY_ACCUMULATOR, 15'h1200, 8'h34, 1'b0);
		`CHK({o_push, o_pc_target}, {1'b1, 15'h1234})
		settle();
	endtask
	task automatic t_returns();
		issue(`OP_RETURN, 15'h0300, 8'h0, 1'b0);
		`CHK({o_pop, o_iret, o_pc_target}, {2'h2, 15'h0abc})
		settle();
		issue(`OP_IRET, 15'h0300, 8'h0, 1'b0);
		`CHK({o_iret, o_pc_load}, 2'h3)
		settle();
		issue(`PAT_RETURN_WITH_LITERAL | 14'h00a5, 15'h0300, 8'h0, 1'b0);
		`CHK({o_pop, o_acc_we, o_acc_wdata}, {2'h3, 8'ha5})
		settle();
	endtask
	task automatic t_sleep();
		issue(`OP_SLEEP, 15'h0050, 8'h0, 1'b0);
		`CHK({o_sleeping, o_powerdown_flag, o_watchdog_expiry_flag}, 3'h5)
		`CHK({o_fetch_next, o_fetch_addr}, {1'b1, 15'h0051})
		repeat (3) next_cycle();
		`CHK({o_busy, o_sleeping}, 2'h3)
		@(posedge i_clk);
		i_wake <= 1'b1;
		@(posedge i_clk);
		i_wake <= 1'b0;
		#1;
		`CHK({o_busy, o_wdt_clear}, 2'h1)
		issue(`OP_WDCLR, 15'h0051, 8'h0, 1'b0);
		`CHK({o_wdt_clear, o_powerdown_flag, o_watchdog_expiry_flag}, 3'h7)
		settle();
	endtask
	task automatic t_inherent();
		issue(`OP_NOP, 15'h0010, 8'h0, 1'b0);
		`CHK({o_pc_load, o_busy, o_acc_we}, 3'h0)
		issue(`OP_PRESCALER, 15'h0011, 8'h3c, 1'b0);
		settle();
		`CHK(o_prescaler_config, 8'h3c)
		for (int f = 0; f < 4; f++) begin
			// selects 5..7 reach the registers, select 0 is refused
			issue(`PAT_DIR | 14'((f + 5) % 8), 15'h0012, 8'ha0 + 8'(f), 1'b0);
			settle();
		end
		`CHK({o_direction_0, o_direction_1, o_direction_2}, 24'ha0a1a2)
		// soft reset last: it may wipe the state the other checks rely on
		issue(`OP_SWRESET, 15'h0013, 8'h0, 1'b0);
		`CHK(o_soft_reset, 1'b1)
		settle();
	endtask
	task automatic stop_test();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#100us;
		err_total++;
		$display("Error %0t: watchdog expired", $time);
		stop_test();
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		`CHK({o_prescaler_config, o_direction_0}, 16'hffff)
		`CHK({o_powerdown_flag, o_watchdog_expiry_flag}, 2'h3)
		t_pointers();
		t_branches();
		t_returns();
		t_sleep();
		t_inherent();
		stop_test();
	end
endmodule
